/* hdl/mq_cpu.sv */
/*
 local processor end: holds local memory, serves the unit's memory
 cycles and walks the list pointers on user commands.
 assumes one command at a time and that the caller checks list status.
*/
`timescale 1ns/10ps
module mq_cpu
    import mq_pkg::*;
#(
    parameter int DEPTH = 1024
)(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // link to the unit
    mq_if.cpu mq,
    // user command port
    input wire logic i_cmd_valid,
    input wire mq_cmd_e i_cmd,
    input wire logic [7:0] i_cmd_addr,
    input wire logic [31:0] i_cmd_data,
    output logic o_busy,
    output logic o_done,
    output logic [31:0] o_data,
    output logic o_irq
);
    localparam int AW = $clog2(DEPTH);

    typedef enum logic [2:0] {F_IDLE, F_PTR, F_MEM, F_SET, F_REG} mq_cpu_e;
    typedef struct packed {
        mq_cpu_e st;
        mq_cmd_e cmd;
        logic [31:0] data;
        logic [31:0] ptr;
        logic [11:0] base;
        logic [2:0] size;
        logic rg_req;
        logic rg_we;
        logic [7:0] rg_addr;
        logic [31:0] rg_wdata;
        logic lb_ack;
        logic [31:0] lb_rdata;
        logic busy;
        logic done;
        logic [31:0] odata;
        logic irq;
    } mq_cpu_s;

    mq_cpu_s r;
    mq_cpu_s next_r;
    logic [31:0] mem [DEPTH];
    logic mem_we;
    logic [AW-1:0] mem_idx;
    logic [31:0] mem_wd;
    logic dev;
    logic wr_cmd;

    // ------------------------------------------------------------
    // command sequencer and memory port
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.rg_req = 1'b0;
        next_r.done = 1'b0;
        next_r.lb_ack = 1'b0;
        next_r.irq = mq.lb_irq;
        mem_we = 1'b0;
        mem_idx = mq.lb_addr[AW+1:2];
        mem_wd = mq.lb_wdata;
        wr_cmd = (r.cmd == CMD_FREE_IN) || (r.cmd == CMD_POST_OUT);
        // unit cycles take priority; ack is a one-cycle pulse
        dev = mq.lb_req && !r.lb_ack;
        if (dev)
        begin
            next_r.lb_ack = 1'b1;
            next_r.lb_rdata = mem[mq.lb_addr[AW+1:2]];
            mem_we = mq.lb_we;
        end
        case (r.st)
            F_IDLE:
                if (i_cmd_valid)
                begin
                    next_r.cmd = i_cmd;
                    next_r.data = i_cmd_data;
                    next_r.busy = 1'b1;
                    next_r.rg_req = 1'b1;
                    next_r.rg_wdata = i_cmd_data;
                    next_r.rg_we = (i_cmd == CMD_REG_WR);
                    next_r.rg_addr = i_cmd_addr;
                    next_r.st = F_REG;
                    // wrap needs base and size, so snoop their setup
                    if (i_cmd == CMD_REG_WR && i_cmd_addr == REG_CTRL_STATUS)
                    begin
                        next_r.base = i_cmd_data[CS_BASE_LSB +: 12];
                        next_r.size = i_cmd_data[CS_SIZE_LSB +: 3];
                    end
                    case (i_cmd)
                        CMD_TAKE_IN: next_r.rg_addr = mq_ptr_off(L_IN_POST, PTR_BOTTOM);
                        CMD_FREE_IN: next_r.rg_addr = mq_ptr_off(L_IN_FREE, PTR_TOP);
                        CMD_GET_OUT: next_r.rg_addr = mq_ptr_off(L_OUT_FREE, PTR_BOTTOM);
                        CMD_POST_OUT: next_r.rg_addr = mq_ptr_off(L_OUT_POST, PTR_TOP);
                        default: ;
                    endcase
                    if (i_cmd != CMD_REG_WR && i_cmd != CMD_REG_RD)
                        next_r.st = F_PTR;
                end
            F_PTR:
                if (mq.rg_ack)
                begin
                    next_r.ptr = mq.rg_rdata;
                    next_r.st = F_MEM;
                end
            F_MEM:
                if (!dev)
                begin
                    mem_idx = r.ptr[AW+1:2];
                    mem_wd = r.data;
                    mem_we = wr_cmd;
                    if (!wr_cmd)
                        next_r.data = mem[r.ptr[AW+1:2]];
                    // whole new pointer value in one register write
                    next_r.rg_req = 1'b1;
                    next_r.rg_we = 1'b1;
                    next_r.rg_wdata = mq_next_ptr(r.ptr, r.base, r.size);
                    next_r.st = F_SET;
                end
            F_SET, F_REG:
                if (mq.rg_ack)
                begin
                    next_r.done = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.odata = (r.st == F_REG) ? mq.rg_rdata : r.data;
                    next_r.st = F_IDLE;
                end
            default: next_r.st = F_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            r <= '0;
        else
            r <= next_r;
    end

    // local memory, no reset: contents are software's business
    always_ff @(posedge i_clk)
    begin
        if (mem_we)
            mem[mem_idx] <= mem_wd;
    end

    assign mq.lb_ack = r.lb_ack;
    assign mq.lb_rdata = r.lb_rdata;
    assign mq.rg_req = r.rg_req;
    assign mq.rg_we = r.rg_we;
    assign mq.rg_addr = r.rg_addr;
    assign mq.rg_wdata = r.rg_wdata;
    assign o_busy = r.busy;
    assign o_done = r.done;
    assign o_data = r.odata;
    assign o_irq = r.irq;
endmodule

/* hdl/mq_if.sv */
/*
 message queue unit link: local memory cycles mastered by the unit,
 register cycles mastered by the local processor, local interrupt.
 assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface mq_if;
    // memory cycles, unit is master
    logic lb_req;
    logic lb_we;
    logic [31:0] lb_addr;
    logic [31:0] lb_wdata;
    logic lb_ack;
    logic [31:0] lb_rdata;
    // register cycles, processor is master
    logic rg_req;
    logic rg_we;
    logic [7:0] rg_addr;
    logic [31:0] rg_wdata;
    logic rg_ack;
    logic [31:0] rg_rdata;
    // local interrupt
    logic lb_irq;

    modport unit (
        output lb_req, lb_we, lb_addr, lb_wdata,
        input lb_ack, lb_rdata,
        input rg_req, rg_we, rg_addr, rg_wdata,
        output rg_ack, rg_rdata, lb_irq
    );
    modport cpu (
        input lb_req, lb_we, lb_addr, lb_wdata,
        output lb_ack, lb_rdata,
        output rg_req, rg_we, rg_addr, rg_wdata,
        input rg_ack, rg_rdata, lb_irq
    );
endinterface

/* hdl/mq_pkg.sv */
/*
 message queue unit: shared constants, register map, types, pointer wrap.
 assumes 32-bit local bus, byte addresses, word-aligned list entries.
*/
package mq_pkg;

    // ------------------------------------------------------------
    // queue port offsets seen from the pci side
    // ------------------------------------------------------------
    localparam logic [11:0] PCI_IN_QUEUE = 12'h040;
    localparam logic [11:0] PCI_OUT_QUEUE = 12'h044;
    localparam logic [31:0] EMPTY_READ = 32'hffff_ffff;

    // ------------------------------------------------------------
    // local-bus register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL_STATUS = 8'h00;
    localparam logic [7:0] REG_GENERAL_IRQ_CONTROL_REG = 8'h04;
    localparam logic [7:0] REG_INT_DIR = 8'h08;
    localparam logic [7:0] REG_INT_STATUS = 8'h0c;
    localparam logic [7:0] REG_OP_MASK = 8'h10;
    localparam logic [7:0] REG_OP_STATUS = 8'h14;
    localparam logic [7:0] REG_PTR_BASE = 8'h20;
    localparam int CS_BASE_LSB = 20;
    localparam int CS_SIZE_LSB = 16;
    localparam int CS_FULL_LSB = 12;
    localparam int CS_EMPTY_LSB = 8;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // ------------------------------------------------------------
    // list numbering and pointer stepping
    // ------------------------------------------------------------
    localparam logic [1:0] L_IN_FREE = 2'h0;
    localparam logic [1:0] L_IN_POST = 2'h1;
    localparam logic [1:0] L_OUT_FREE = 2'h2;
    localparam logic [1:0] L_OUT_POST = 2'h3;
    localparam logic PTR_BOTTOM = 1'b0;
    localparam logic PTR_TOP = 1'b1;
    localparam logic [19:0] PTR_STEP = 20'h00004;
    localparam logic [31:0] FIFO_BYTES_MIN = 32'h0000_0400;

    typedef enum logic [2:0] {
        CMD_TAKE_IN,
        CMD_FREE_IN,
        CMD_GET_OUT,
        CMD_POST_OUT,
        CMD_REG_WR,
        CMD_REG_RD
    } mq_cmd_e;

    // next entry of a list, wrapping inside the configured size
    function automatic logic [31:0] mq_next_ptr(input logic [31:0] p,
        input logic [11:0] base, input logic [2:0] size);
        logic [19:0] m;
        m = 20'((FIFO_BYTES_MIN << size) - 32'h1);
        return {base, (p[19:0] & ~m) | ((p[19:0] + PTR_STEP) & m)};
    endfunction

    // register offset of a list pointer
    function automatic logic [7:0] mq_ptr_off(input logic [1:0] l, input logic t);
        return REG_PTR_BASE | {3'h0, l, t, 2'h0};
    endfunction

endpackage

/* hdl/mq_unit.sv */
/*
 message queue unit: pci queue ports turned into delayed local-bus
 cycles on four circular lists in local memory, pointer upkeep,
 list status and interrupts.
 assumes pci requests come one at a time and are repeated on retry.
*/
// Contract
// - inbound read fetches at free bottom, advances
// - inbound write stores at post top, advances
// - new inbound post sets flag, local irq
// - writing one clears new-entry flag
// - processor advances inbound post bottom pointer
// - processor releases frame, raises free top
// - processor takes outbound free, advances bottom
// - processor posts outbound, raises post top
// - outbound post not empty sets flag, irq
// - outbound read fetches at post bottom, advances
// - outbound flag clears when list empties
// - outbound write stores, top advances after completion
// - unit pointers wrap modulo configured size
// - no top advance when list full
// - no bottom advance when list empty
// - processor pointers change by full register write
// - empty and full status per list
// - outbound pending mirrored in interrupt status
// - free lists empty, inbound post or outbound free full raise enabled interrupts
// - pointers share upper twelve bits with base
// - equal pointers at start mean empty
// - read of empty list returns all ones
`timescale 1ns/10ps
module mq_unit
    import mq_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pci target side
    input wire logic i_pci_req,
    input wire logic i_pci_we,
    input wire logic [11:0] i_pci_addr,
    input wire logic [31:0] i_pci_wdata,
    output logic o_pci_ack,
    output logic o_pci_retry,
    output logic [31:0] o_pci_rdata,
    output logic o_pci_irq,
    // local bus side
    mq_if.unit mq
);
    typedef enum logic [1:0] {P_IDLE, P_BUSY, P_DONE} mq_pend_e;
    typedef struct packed {
        mq_pend_e st;
        logic port;
        logic we;
        logic [31:0] data;
        logic lb_req;
        logic lb_we;
        logic [31:0] lb_addr;
        logic [31:0] lb_wdata;
        logic pci_ack;
        logic pci_retry;
        logic [31:0] pci_rdata;
        logic rg_ack;
        logic [31:0] rg_rdata;
        logic [3:0][1:0][31:0] ptr;
        logic [3:0] full;
        logic [11:0] base;
        logic [2:0] size;
        logic ipn;
        logic [4:0] ctl;
        logic [3:0] dir;
        logic mask;
        logic lb_irq;
        logic pci_irq;
    } mq_unit_s;

    mq_unit_s r;
    mq_unit_s next_r;
    logic [3:0] empty;
    logic [3:0] ext;
    logic [1:0] pf;
    logic pt;
    logic [31:0] pv;
    logic is_q;
    logic qp;
    logic [1:0] rf;
    logic [1:0] wf;
    logic [1:0] cwf;
    logic [31:0] nt;

    // ------------------------------------------------------------
    // list status
    // ------------------------------------------------------------
    // equal pointers are empty unless a top advance caught the bottom
    always_comb
    begin
        for (int f = 0; f < 4; f++)
            empty[f] = (r.ptr[f][0] == r.ptr[f][1]) && !r.full[f];
        ext = {r.full[L_OUT_FREE], r.full[L_IN_POST],
            empty[L_OUT_FREE], empty[L_IN_FREE]} & r.ctl[4:1];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.pci_ack = 1'b0;
        next_r.pci_retry = 1'b0;
        next_r.rg_ack = 1'b0;
        pf = mq.rg_addr[4:3];
        pt = mq.rg_addr[2];
        pv = {r.base, mq.rg_wdata[19:0]};
        is_q = (i_pci_addr == PCI_IN_QUEUE) || (i_pci_addr == PCI_OUT_QUEUE);
        qp = (i_pci_addr == PCI_OUT_QUEUE);
        rf = qp ? L_OUT_POST : L_IN_FREE;
        wf = qp ? L_OUT_FREE : L_IN_POST;
        cwf = r.port ? L_OUT_FREE : L_IN_POST;
        nt = mq_next_ptr(r.ptr[cwf][1], r.base, r.size);

        // register access; answered one cycle after the request
        if (mq.rg_req)
        begin
            next_r.rg_ack = 1'b1;
            next_r.rg_rdata = RST_WORD;
            if (mq.rg_addr[7:5] == REG_PTR_BASE[7:5])
            begin
                next_r.rg_rdata = r.ptr[pf][pt];
                if (mq.rg_we)
                begin
                    next_r.ptr[pf][pt] = pv;
                    // only a top stepped onto its bottom marks the list full;
                    // set-up writes of equal pointers must leave it empty
                    next_r.full[pf] = pt && (pv == r.ptr[pf][0])
                        && (pv == mq_next_ptr(r.ptr[pf][1], r.base, r.size));
                end
            end
            else
                case (mq.rg_addr)
                    REG_CTRL_STATUS:
                    begin
                        next_r.rg_rdata[CS_BASE_LSB +: 12] = r.base;
                        next_r.rg_rdata[CS_SIZE_LSB +: 3] = r.size;
                        next_r.rg_rdata[CS_FULL_LSB +: 4] = r.full;
                        next_r.rg_rdata[CS_EMPTY_LSB +: 4] = empty;
                        if (mq.rg_we)
                        begin
                            next_r.base = mq.rg_wdata[CS_BASE_LSB +: 12];
                            next_r.size = mq.rg_wdata[CS_SIZE_LSB +: 3];
                        end
                    end
                    REG_GENERAL_IRQ_CONTROL_REG:
                    begin
                        next_r.rg_rdata[4:0] = r.ctl;
                        if (mq.rg_we)
                            next_r.ctl = mq.rg_wdata[4:0];
                    end
                    REG_INT_DIR:
                    begin
                        next_r.rg_rdata[4:1] = r.dir;
                        if (mq.rg_we)
                            next_r.dir = mq.rg_wdata[4:1];
                    end
                    REG_INT_STATUS:
                    begin
                        next_r.rg_rdata[0] = r.ipn;
                        next_r.rg_rdata[1] = !empty[L_OUT_POST];
                        if (mq.rg_we && mq.rg_wdata[0])
                            next_r.ipn = 1'b0;
                    end
                    REG_OP_MASK:
                    begin
                        next_r.rg_rdata[0] = r.mask;
                        if (mq.rg_we)
                            next_r.mask = mq.rg_wdata[0];
                    end
                    REG_OP_STATUS: next_r.rg_rdata[0] = !empty[L_OUT_POST];
                    default: ;
                endcase
        end

        // pci queue ports; one delayed cycle in flight at a time
        if (i_pci_req)
        begin
            if (!is_q)
            begin
                next_r.pci_ack = 1'b1;
                next_r.pci_rdata = RST_WORD;
            end
            else if (r.st == P_IDLE)
            begin
                if (!i_pci_we && empty[rf])
                begin
                    next_r.pci_ack = 1'b1;
                    next_r.pci_rdata = EMPTY_READ;
                end
                else if (i_pci_we && r.full[wf])
                    next_r.pci_ack = 1'b1; // dropped, list has no room
                else
                begin
                    // start delayed cycle, pci must come back
                    next_r.pci_retry = 1'b1;
                    next_r.st = P_BUSY;
                    next_r.port = qp;
                    next_r.we = i_pci_we;
                    next_r.lb_req = 1'b1;
                    next_r.lb_we = i_pci_we;
                    next_r.lb_wdata = i_pci_wdata;
                    next_r.lb_addr = i_pci_we ? r.ptr[wf][1] : r.ptr[rf][0];
                end
            end
            else if (r.st == P_DONE && r.port == qp && r.we == i_pci_we)
            begin
                next_r.pci_ack = 1'b1;
                next_r.pci_rdata = r.data;
                next_r.st = P_IDLE;
                // bottom moves once the word is delivered
                if (!r.we && !empty[rf])
                begin
                    next_r.ptr[rf][0] = mq_next_ptr(r.ptr[rf][0], r.base, r.size);
                    next_r.full[rf] = 1'b0;
                end
            end
            else
                next_r.pci_retry = 1'b1;
        end

        // local cycle completion
        if (r.st == P_BUSY && mq.lb_ack)
        begin
            next_r.lb_req = 1'b0;
            next_r.st = P_DONE;
            next_r.data = mq.lb_rdata;
            if (r.we && !r.full[cwf])
            begin
                next_r.ptr[cwf][1] = nt;
                next_r.full[cwf] = (nt == r.ptr[cwf][0]);
                if (!r.port)
                    next_r.ipn = 1'b1;
            end
        end

        // interrupts; direction bit sends a source to pci
        next_r.lb_irq = (r.ipn && r.ctl[0]) || |(ext & ~r.dir);
        next_r.pci_irq = (!empty[L_OUT_POST] && !r.mask) || |(ext & r.dir);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            r <= '0;
        else
            r <= next_r;
    end

    // outputs straight from the state register
    assign o_pci_ack = r.pci_ack;
    assign o_pci_retry = r.pci_retry;
    assign o_pci_rdata = r.pci_rdata;
    assign o_pci_irq = r.pci_irq;
    assign mq.lb_req = r.lb_req;
    assign mq.lb_we = r.lb_we;
    assign mq.lb_addr = r.lb_addr;
    assign mq.lb_wdata = r.lb_wdata;
    assign mq.rg_ack = r.rg_ack;
    assign mq.rg_rdata = r.rg_rdata;
    assign mq.lb_irq = r.lb_irq;
endmodule

/* tb/mq_props.sv */
/*
 checker for the message queue link and the pci port of the unit.
 assumes one clock, sync high reset, instanced beside the link.
*/
`timescale 1ns/10ps
module mq_props (
    // clock and reset
    input logic i_clk,
    input logic i_rst,
    // link signals
    input logic lb_req,
    input logic lb_we,
    input logic [31:0] lb_addr,
    input logic [31:0] lb_wdata,
    input logic lb_ack,
    input logic rg_req,
    input logic rg_ack,
    // pci port
    input logic i_pci_req,
    input logic i_pci_we,
    input logic [31:0] i_pci_wdata,
    input logic o_pci_ack,
    input logic o_pci_retry
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_rg_answer_next: assert property (rg_req |=> rg_ack)
        else $error("register access not answered next cycle");
    a_rg_no_stray: assert property (rg_ack |-> $past(rg_req))
        else $error("register answer without request");
    a_pci_one_answer: assert property (i_pci_req |=> o_pci_ack != o_pci_retry)
        else $error("pci request not answered by exactly one of ack, retry");
    a_pci_no_stray: assert property ((o_pci_ack || o_pci_retry) |-> $past(i_pci_req))
        else $error("pci answer without request");
    // a memory cycle only ever starts from the pci access just taken
    a_lb_from_pci: assert property ($rose(lb_req) |-> $past(i_pci_req) && lb_we == $past(i_pci_we))
        else $error("memory cycle not caused by a pci access");
    a_lb_write_data: assert property ($rose(lb_req) && lb_we |-> lb_wdata == $past(i_pci_wdata))
        else $error("memory write data differs from pci data");
    a_lb_held_stable: assert property (lb_req && !lb_ack |=> lb_req && $stable(lb_addr) && $stable(lb_wdata))
        else $error("memory request dropped or changed before ack");
    a_lb_served: assert property ($rose(lb_req) |=> lb_ack)
        else $error("memory cycle not served next cycle");
    a_lb_word_addr: assert property (lb_req |-> lb_addr[1:0] == 2'h0)
        else $error("memory address not word aligned");
endmodule

/* tb/testbench.sv */
/*
 testbench: unit and processor end joined by the link; pci port and
 command port driven here, expectations from bench arithmetic.
 assumes lists of 0x400 bytes at 0x000, 0x400, 0x800 and 0xc00.
*/
`timescale 1ns/10ps
module testbench
    import mq_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic pci_req = 1'b0;
    logic pci_we = 1'b0;
    logic [11:0] pci_addr = 12'h000;
    logic [31:0] pci_wdata = 32'h0;
    logic cmd_valid = 1'b0;
    mq_cmd_e cmd = CMD_REG_RD;
    logic [7:0] cmd_addr = 8'h00;
    logic [31:0] cmd_data = 32'h0;
    logic pci_ack, pci_retry, pci_irq, busy, done, cpu_irq;
    logic [31:0] pci_rdata, cpu_data, q;
    logic [31:0] m [3];
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    mq_if lnk();
    mq_unit mq_unit_i (.i_clk(i_clk), .i_rst(i_rst), .i_pci_req(pci_req), .i_pci_we(pci_we),
        .i_pci_addr(pci_addr), .i_pci_wdata(pci_wdata), .o_pci_ack(pci_ack),
        .o_pci_retry(pci_retry), .o_pci_rdata(pci_rdata), .o_pci_irq(pci_irq), .mq(lnk));
    mq_cpu mq_cpu_i (.i_clk(i_clk), .i_rst(i_rst), .mq(lnk), .i_cmd_valid(cmd_valid),
        .i_cmd(cmd), .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data), .o_busy(busy),
        .o_done(done), .o_data(cpu_data), .o_irq(cpu_irq));
    mq_props mq_props_i (.i_clk(i_clk), .i_rst(i_rst), .lb_req(lnk.lb_req), .lb_we(lnk.lb_we),
        .lb_addr(lnk.lb_addr), .lb_wdata(lnk.lb_wdata), .lb_ack(lnk.lb_ack),
        .rg_req(lnk.rg_req), .rg_ack(lnk.rg_ack), .i_pci_req(pci_req), .i_pci_we(pci_we),
        .i_pci_wdata(pci_wdata), .o_pci_ack(pci_ack), .o_pci_retry(pci_retry));

    // ------------------------------------------------------------
    // clock, hang guard, helpers
    // ------------------------------------------------------------
    initial
    begin
        forever #4 i_clk = ~i_clk;
    end

    // full fill of a list takes about 1550 cycles, six per accepted write; leave margin
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // pointer after n steps inside a 0x400-byte list
    function automatic logic [31:0] nxt(input logic [31:0] p, input int n);
        return {p[31:10], 10'(p[9:0] + 10'(n * 4))};
    endfunction

    // pci access, repeated while the unit answers retry
    task automatic pci(input logic we, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        while (k < 40)
        begin
            @(posedge i_clk);
            pci_req <= 1'b1;
            pci_we <= we;
            pci_addr <= a;
            pci_wdata <= d;
            @(posedge i_clk);
            pci_req <= 1'b0;
            #1;
            if (pci_ack !== 1'b1 && pci_retry !== 1'b1)
            begin
                @(posedge i_clk);
                #1;
            end
            k = (pci_ack === 1'b1) ? 40 : k + 1;
        end
        q = pci_rdata;
    endtask

    // one processor command, waits for its done pulse
    task automatic run(input mq_cmd_e c, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge i_clk);
        cmd_valid <= 1'b0;
        #1;
        chk({31'h0, busy}, 32'h1);
        for (k = 0; k < 200 && done !== 1'b1; k++)
        begin
            @(posedge i_clk);
            #1;
        end
        q = cpu_data;
    endtask

    task automatic rd(input logic [7:0] a);
        run(CMD_REG_RD, a, 32'h0);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(59));
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        run(CMD_REG_WR, REG_CTRL_STATUS, 32'h0);
        for (int l = 1; l < 4; l++)
        begin
            run(CMD_REG_WR, 8'(8'h20 + 8 * l), 32'(l * 32'h400));
            run(CMD_REG_WR, 8'(8'h24 + 8 * l), 32'(l * 32'h400));
        end
        run(CMD_REG_WR, REG_GENERAL_IRQ_CONTROL_REG, 32'h1);
        rd(REG_CTRL_STATUS);
        chk(q, 32'h0000_0f00);
        pci(1'b0, PCI_IN_QUEUE, 32'h0);
        chk(q, 32'hffff_ffff);
        pci(1'b0, PCI_OUT_QUEUE, 32'h0);
        chk(q, 32'hffff_ffff);
        // released frames come back to pci in order
        foreach (m[i])
        begin
            m[i] = $urandom & 32'h7fff_fff0;
            run(CMD_FREE_IN, 8'h00, m[i]);
        end
        foreach (m[i])
        begin
            pci(1'b0, PCI_IN_QUEUE, 32'h0);
            chk(q, m[i]);
        end
        pci(1'b0, PCI_IN_QUEUE, 32'h0);
        chk(q, 32'hffff_ffff);
        rd(8'h20);
        chk(q, nxt(32'h0, 3));
        // inbound post, new-entry flag and its clear
        m[0] = $urandom & 32'h7fff_fff0;
        pci(1'b1, PCI_IN_QUEUE, m[0]);
        repeat (3) @(posedge i_clk);
        #1;
        chk({31'h0, cpu_irq}, 32'h1);
        rd(8'h2c);
        chk(q, nxt(32'h400, 1));
        run(CMD_REG_WR, REG_INT_STATUS, 32'h0);
        rd(REG_INT_STATUS);
        chk(q, 32'h1);
        run(CMD_REG_WR, REG_INT_STATUS, 32'h1);
        rd(REG_INT_STATUS);
        chk(q, 32'h0);
        chk({31'h0, cpu_irq}, 32'h0);
        run(CMD_TAKE_IN, 8'h00, 32'h0);
        chk(q, m[0]);
        // outbound free and post, with and without the mask
        m[1] = $urandom & 32'h7fff_fff0;
        pci(1'b1, PCI_OUT_QUEUE, m[1]);
        rd(8'h34);
        chk(q, nxt(32'h800, 1));
        run(CMD_GET_OUT, 8'h00, 32'h0);
        chk(q, m[1]);
        for (int mk = 0; mk < 2; mk++)
        begin
            run(CMD_REG_WR, REG_OP_MASK, 32'(mk));
            m[2] = $urandom & 32'h7fff_fff0;
            run(CMD_POST_OUT, 8'h00, m[2]);
            repeat (3) @(posedge i_clk);
            #1;
            chk({31'h0, pci_irq}, 32'(1 - mk));
            rd(REG_INT_STATUS);
            chk(q, 32'h2);
            pci(1'b0, PCI_OUT_QUEUE, 32'h0);
            chk(q, m[2]);
            rd(REG_OP_STATUS);
            chk(q, 32'h0);
            chk({31'h0, pci_irq}, 32'h0);
        end
        // fill the inbound post list past full; last write is dropped
        for (int i = 0; i < 257; i++)
        begin
            pci(1'b1, PCI_IN_QUEUE, 32'(32'h1000 + i));
            if (i == 254)
            begin
                rd(8'h2c);
                chk(q, nxt(32'h404, 255));
            end
        end
        rd(8'h2c);
        chk(q, 32'h404);
        rd(REG_CTRL_STATUS);
        chk(q, 32'h0000_2d00);
        // full inbound post list as a source, first local then pci
        run(CMD_REG_WR, REG_GENERAL_IRQ_CONTROL_REG, 32'h8);
        repeat (3) @(posedge i_clk);
        #1;
        chk({30'h0, pci_irq, cpu_irq}, 32'h1);
        run(CMD_REG_WR, REG_INT_DIR, 32'h8);
        repeat (3) @(posedge i_clk);
        #1;
        chk({30'h0, pci_irq, cpu_irq}, 32'h2);
        run(CMD_TAKE_IN, 8'h00, 32'h0);
        chk(q, 32'h1000);
        rd(REG_CTRL_STATUS);
        chk(q, 32'h0000_0d00);
        chk({30'h0, pci_irq, cpu_irq}, 32'h0);
        give_verdict();
    end
endmodule
